// File: rtl/lpddr_cmd_core.sv
// Purpose: Command level core of a low-power DDR memory device.
// Assumes: Commands and write pairs come from logic on core_clk.
// Notes: One data pair (two words) per cycle; write pair k is taken k+1 edges after WRITE.
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
`include "lpddr_defines.svh"
module lpddr_cmd_core #(
   parameter int COL_W = 6,
   parameter int ROW_W = 12,
   parameter logic [3:0] RP_CYC = 4'(`ROW_PRECHARGE_CYC),
   parameter logic [3:0] WR_CYC = 4'(`WRITE_RECOVERY_CYC),
   parameter logic [15:0] SR_INTERVAL = 16'(`SR_INTERVAL_CYC)
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic ce,
   input wire lpddr_pkg::cmd_bus_t cmd,
   input wire lpddr_pkg::wr_pair_t wr,
   output lpddr_pkg::rd_pair_t rd,
   input wire logic [1:0] temp_code,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   lpddr_pkg::cmd_code_t code;
   lpddr_pkg::burst_state_t eng_r;
   lpddr_pkg::power_state_t pwr_r;
   lpddr_pkg::rd_pair_t stage_r;
   lpddr_pkg::rd_pair_t rd_r;
   logic [1:0] bank;
   logic cmd_ok;
   logic [6:0] mode_r;
   logic [12:0] ext_mode_r;
   logic status_sel_r;
   logic [3:0] bank_open_r;
   logic [3:0] bank_cnt_r [4];
   logic [3:0] bank_busy;
   logic [3:0] pre_sel;
   logic [1:0] eng_bank_r;
   logic [COL_W-1:0] eng_col_r;
   logic [3:0] eng_idx_r;
   logic eng_ap_r;
   logic eng_status_r;
   logic [3:0] words;
   logic last_pair;
   logic start_rw;
   logic start_srr;
   logic cut;
   logic ap_fire;
   logic [3:0] ap_mask;
   logic self_enter;
   logic [COL_W-1:0] col0;
   logic [COL_W-1:0] col1;
   logic [15:0] mem [0:(4 << COL_W)-1];
   logic [31:0] rd_now;
   logic [2:0] mrs_bl;
   logic [12:0] mrs_addr;
   logic ack_r;
   logic [31:0] readdata_r;
   logic [15:0] sr_interval_r;
   logic [ROW_W-1:0] refresh_row;
   logic [15:0] refresh_total;

   // Words per burst from the programmed length code.
   function automatic logic [3:0] burst_words(input logic [2:0] bl);
      case (bl)
         `BL_CODE_2: burst_words = 4'h2;
         `BL_CODE_8: burst_words = 4'h8;
         default: burst_words = 4'h4;
      endcase
   endfunction : burst_words

   function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                  input logic [3:0] idx,
                                                  input logic [3:0] nwords,
                                                  input logic interleave);
      logic [COL_W-1:0] m;
      logic [COL_W-1:0] off;
      m = COL_W'(nwords - 4'h1);
      off = interleave ? (start ^ COL_W'(idx)) : COL_W'(start + COL_W'(idx));
      burst_col = (start & ~m) | (off & m);
   endfunction : burst_col

   assign bank = {cmd.bank_select_high, cmd.bank_select_low};
   assign code = cmd.cs_n ? lpddr_pkg::cmd_nop
                          : lpddr_pkg::cmd_code_t'({1'b0, cmd.ras_n, cmd.cas_n, cmd.we_n});
   // Command inputs other than clock enable are ignored while in self refresh.
   assign cmd_ok = cmd.cke && (pwr_r == lpddr_pkg::st_normal);
   assign mrs_bl = cmd.addr[`MR_BL_LSB +: 3];
   assign mrs_addr = cmd.addr;

   always_comb
   begin
      for (int b = 0; b < 4; b++)
         bank_busy[b] = (bank_cnt_r[b] != 4'h0);
   end

   always_comb
   begin
      pre_sel = 4'h0;
      if (cmd_ok && code == lpddr_pkg::cmd_pre)
         pre_sel = cmd.addr[`PRECHARGE_SCOPE_BIT] ? 4'hF : 4'(4'h1 << bank);
   end

   assign words = eng_status_r ? 4'h2 : burst_words(mode_r[`MR_BL_LSB +: 3]);
   assign last_pair = (5'(eng_idx_r) + 5'h2) >= 5'(words);
   assign start_srr = cmd_ok && code == lpddr_pkg::cmd_read && status_sel_r;
   assign start_rw = cmd_ok && !status_sel_r && bank_open_r[bank]
                     && (code == lpddr_pkg::cmd_read || code == lpddr_pkg::cmd_write);
   // burst cut by precharge or terminate.
   assign cut = (eng_r != lpddr_pkg::eng_idle) && (pre_sel[eng_bank_r]
                || (eng_r == lpddr_pkg::eng_read && !eng_ap_r && cmd_ok
                    && code == lpddr_pkg::cmd_bst));
   assign ap_fire = (eng_r != lpddr_pkg::eng_idle) && eng_ap_r && last_pair && !cut;
   assign ap_mask = ap_fire ? 4'(4'h1 << eng_bank_r) : 4'h0;

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         eng_r <= lpddr_pkg::eng_idle;
         eng_bank_r <= 2'h0;
         eng_col_r <= '0;
         eng_idx_r <= 4'h0;
         eng_ap_r <= 1'b0;
         eng_status_r <= 1'b0;
      end
      else if (ce)
      begin
         if (start_rw || start_srr)
         begin
            eng_r <= (code == lpddr_pkg::cmd_read) ? lpddr_pkg::eng_read
                                                   : lpddr_pkg::eng_write;
            eng_bank_r <= bank;
            eng_col_r <= cmd.addr[COL_W-1:0];
            eng_idx_r <= 4'h0;
            eng_ap_r <= start_rw && cmd.addr[`PRECHARGE_SCOPE_BIT];
            eng_status_r <= start_srr;
         end
         else if (eng_r != lpddr_pkg::eng_idle)
         begin
            if (last_pair || cut)
               eng_r <= lpddr_pkg::eng_idle;
            eng_idx_r <= 4'(eng_idx_r + 4'h2);
         end
      end
   end

   assign col0 = burst_col(eng_col_r, eng_idx_r, words, mode_r[`MR_BT_BIT]);
   assign col1 = burst_col(eng_col_r, 4'(eng_idx_r + 4'h1), words, mode_r[`MR_BT_BIT]);
   assign rd_now = eng_status_r ? `STATUS_ID : {mem[{eng_bank_r, col1}], mem[{eng_bank_r, col0}]};

   // only pairs taken before the cut are stored.
   always_ff @(posedge core_clk)
   begin
      if (ce && eng_r == lpddr_pkg::eng_write && !cut)
      begin
         if (!wr.write_byte_mask[0])
            mem[{eng_bank_r, col0}][7:0] <= wr.data[7:0];
         if (!wr.write_byte_mask[1])
            mem[{eng_bank_r, col0}][15:8] <= wr.data[15:8];
         if (!wr.write_byte_mask[2])
            mem[{eng_bank_r, col1}][7:0] <= wr.data[23:16];
         if (!wr.write_byte_mask[3])
            mem[{eng_bank_r, col1}][15:8] <= wr.data[31:24];
      end
   end

   // one extra stage for latency three.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         stage_r <= '0;
         rd_r <= '0;
      end
      else if (ce)
      begin
         stage_r <= {(eng_r == lpddr_pkg::eng_read), rd_now};
         if (mode_r[`MR_CL_LSB +: 3] == `CL_CODE_3)
            rd_r <= stage_r;
         else
            rd_r <= {(eng_r == lpddr_pkg::eng_read), rd_now};
      end
   end
   assign rd = rd_r;

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bank_open_r <= 4'h0;
         for (int b = 0; b < 4; b++)
            bank_cnt_r[b] <= 4'h0;
      end
      else if (ce)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (ap_mask[b])
            begin
               bank_open_r[b] <= 1'b0;
               bank_cnt_r[b] <= (eng_r == lpddr_pkg::eng_write) ? 4'(WR_CYC + RP_CYC) : RP_CYC;
            end
            else if (pre_sel[b] && bank_open_r[b])
            begin
               bank_open_r[b] <= 1'b0;
               bank_cnt_r[b] <= RP_CYC;
            end
            else if (cmd_ok && code == lpddr_pkg::cmd_act && bank == 2'(b)
                     && !bank_open_r[b] && !bank_busy[b])
               bank_open_r[b] <= 1'b1;
            else if (bank_busy[b])
               bank_cnt_r[b] <= 4'(bank_cnt_r[b] - 4'h1);
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         mode_r <= `MR_RESET;
         ext_mode_r <= `EMR_RESET;
         status_sel_r <= 1'b0;
      end
      else if (ce)
      begin
         if (cmd_ok && code == lpddr_pkg::cmd_mrs)
         begin
            case (bank)
               2'h0:
               begin
                  if (mrs_bl == `BL_CODE_2 || mrs_bl == `BL_CODE_4 || mrs_bl == `BL_CODE_8)
                     mode_r[`MR_BL_LSB +: 3] <= mrs_bl;
                  mode_r[`MR_BT_BIT] <= cmd.addr[`MR_BT_BIT];
                  if (cmd.addr[`MR_CL_LSB +: 3] == `CL_CODE_2
                      || cmd.addr[`MR_CL_LSB +: 3] == `CL_CODE_3)
                     mode_r[`MR_CL_LSB +: 3] <= cmd.addr[`MR_CL_LSB +: 3];
               end
               2'h2: ext_mode_r <= cmd.addr;
               2'h1: status_sel_r <= (cmd.addr[11:0] == 12'h000);
               default: status_sel_r <= status_sel_r;
            endcase
         end
         else if (start_srr)
            status_sel_r <= 1'b0;
      end
   end

   // self refresh entry on refresh with clock enable low.
   assign self_enter = (pwr_r == lpddr_pkg::st_normal) && !cmd.cke
                       && code == lpddr_pkg::cmd_ref;

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         pwr_r <= lpddr_pkg::st_normal;
      else if (ce)
      begin
         case (pwr_r)
            lpddr_pkg::st_normal:
               if (self_enter)
                  pwr_r <= lpddr_pkg::st_self;
            lpddr_pkg::st_self:
               if (cmd.cke)
                  pwr_r <= lpddr_pkg::st_normal;
            default: pwr_r <= lpddr_pkg::st_normal;
         endcase
      end
   end

   lpddr_refresh_engine #(
      .ROW_W(ROW_W)
   ) u_refresh (
      .core_clk(core_clk),
      .resetn(resetn),
      .ce(ce),
      .auto_req(cmd_ok && code == lpddr_pkg::cmd_ref),
      .self_active(pwr_r == lpddr_pkg::st_self),
      .self_enter(self_enter),
      .temp_code(temp_code),
      .array_code(ext_mode_r[2:0]),
      .interval(sr_interval_r),
      .refresh_row_r(refresh_row),
      .refresh_total_r(refresh_total)
   );

   // One wait cycle lets read data settle in a register before the master samples it.
   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
   assign avs_readdata = readdata_r;

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ack_r <= 1'b0;
         readdata_r <= 32'h0000_0000;
         sr_interval_r <= SR_INTERVAL;
      end
      else if (ce)
      begin
         ack_r <= (avs_read || avs_write) && !ack_r;
         if (avs_read && !ack_r)
         begin
            case (avs_address)
               `REG_STATUS: readdata_r <= {20'h0, (pwr_r == lpddr_pkg::st_self),
                                           (eng_r != lpddr_pkg::eng_idle), status_sel_r,
                                           1'b0, bank_busy, bank_open_r};
               `REG_MODE: readdata_r <= {3'h0, ext_mode_r, 9'h0, mode_r};
               `REG_REFRESH_TOTAL: readdata_r <= {16'h0, refresh_total};
               `REG_SR_INTERVAL: readdata_r <= {16'h0, sr_interval_r};
               `REG_REFRESH_ROW: readdata_r <= 32'(refresh_row);
               default: readdata_r <= 32'h0000_0000;
            endcase
         end
         if (avs_write && ack_r && avs_address == `REG_SR_INTERVAL)
            sr_interval_r <= avs_writedata[15:0];
      end
   end

   chk_bst_read_cut:
   assert property (@(posedge core_clk) disable iff (!resetn)
      ce && eng_r == lpddr_pkg::eng_read && !eng_ap_r && cmd_ok && code == lpddr_pkg::cmd_bst
      |=> eng_r == lpddr_pkg::eng_idle)
      else $error("burst terminate did not end read");

   chk_write_cut_pre:
   assert property (@(posedge core_clk) disable iff (!resetn)
      ce && eng_r == lpddr_pkg::eng_write && pre_sel[eng_bank_r] && !start_rw
      |=> eng_r == lpddr_pkg::eng_idle)
      else $error("precharge did not cut write burst");

   chk_pre_all_banks:
   assert property (@(posedge core_clk) disable iff (!resetn)
      ce && pre_sel == 4'hF |=> bank_open_r == 4'h0)
      else $error("precharge all left a bank open");

   chk_pre_idle_noop:
   assert property (@(posedge core_clk) disable iff (!resetn)
      ce && pre_sel != 4'h0 && (pre_sel & bank_open_r) == 4'h0 && !ap_fire
      |=> $stable(bank_open_r))
      else $error("precharge of idle bank changed state");

   chk_auto_pre_start:
   assert property (@(posedge core_clk) disable iff (!resetn)
      ce && ap_fire |=> (bank_busy & $past(ap_mask)) != 4'h0 && (bank_open_r & $past(ap_mask)) == 4'h0)
      else $error("auto precharge did not start");

   chk_read_lat_two:
   assert property (@(posedge core_clk) disable iff (!resetn)
      ce && (start_rw || start_srr) && code == lpddr_pkg::cmd_read
      && mode_r[`MR_CL_LSB +: 3] == `CL_CODE_2 ##1 ce |=> rd_r.valid)
      else $error("latency two read data late");

   chk_read_lat_three:
   assert property (@(posedge core_clk) disable iff (!resetn)
      ce && (start_rw || start_srr) && code == lpddr_pkg::cmd_read
      && mode_r[`MR_CL_LSB +: 3] == `CL_CODE_3 ##1 ce ##1 ce |=> rd_r.valid)
      else $error("latency three read data late");

   chk_mrs_burst_len:
   assert property (@(posedge core_clk) disable iff (!resetn)
      ce && cmd_ok && code == lpddr_pkg::cmd_mrs && bank == 2'h0 && mrs_bl == `BL_CODE_8
      |=> mode_r[`MR_BL_LSB +: 3] == $past(mrs_bl))
      else $error("burst length not loaded");

   chk_ext_mode_load:
   assert property (@(posedge core_clk) disable iff (!resetn)
      ce && cmd_ok && code == lpddr_pkg::cmd_mrs && bank == 2'h2
      |=> ext_mode_r == $past(mrs_addr))
      else $error("extended mode not loaded");

   chk_status_select:
   assert property (@(posedge core_clk) disable iff (!resetn)
      ce && cmd_ok && code == lpddr_pkg::cmd_mrs && bank == 2'h1 && mrs_addr[11:0] == 12'h000
      |=> status_sel_r ##0 (!ce || !cmd_ok || code != lpddr_pkg::cmd_read)
          or status_sel_r ##1 (!ce || eng_status_r))
      else $error("status register not selected");

endmodule : lpddr_cmd_core

// File: common/lpddr_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the command core.
// Assumes: core_clk runs at 250 MHz.
// Notes: Included by bare name; definitions only.
`ifndef LPDDR_DEFINES_SVH
`define LPDDR_DEFINES_SVH

`define CLK_PERIOD_NS 4
`define ROW_PRECHARGE_NS 18
`define ROW_PRECHARGE_CYC ((`ROW_PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_RECOVERY_NS 15
`define WRITE_RECOVERY_CYC ((`WRITE_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SR_INTERVAL_NS 7800
`define SR_INTERVAL_CYC (`SR_INTERVAL_NS / `CLK_PERIOD_NS)

`define PRECHARGE_SCOPE_BIT 10
`define MR_BL_LSB 0
`define MR_BT_BIT 3
`define MR_CL_LSB 4
`define MR_RESET 7'h32
`define EMR_RESET 13'h0000
`define BL_CODE_2 3'h1
`define BL_CODE_4 3'h2
`define BL_CODE_8 3'h3
`define CL_CODE_2 3'h2
`define CL_CODE_3 3'h3
`define ARRAY_HALF 3'h1
`define ARRAY_QUARTER 3'h2
`define ARRAY_EIGHTH 3'h5
`define ARRAY_SIXTEENTH 3'h6

`define REG_STATUS 6'h00
`define REG_MODE 6'h04
`define REG_REFRESH_TOTAL 6'h08
`define REG_SR_INTERVAL 6'h0C
`define REG_REFRESH_ROW 6'h10

// Arbitrary neutral value returned by the status register read.
`define STATUS_ID 32'h00A5_5A00

`endif

// File: common/lpddr_pkg.sv
// Purpose: Types shared by the command core, the controller model and the bench.
// Assumes: Nothing beyond the defines header.
// Notes: Command codes are {ras_n, cas_n, we_n} with chip select asserted.
package lpddr_pkg;

   typedef enum logic [3:0] {
      cmd_mrs = 4'h0,
      cmd_ref = 4'h1,
      cmd_pre = 4'h2,
      cmd_act = 4'h3,
      cmd_write = 4'h4,
      cmd_read = 4'h5,
      cmd_bst = 4'h6,
      cmd_nop = 4'h7
   } cmd_code_t;

   typedef enum logic [2:0] {
      eng_idle = 3'b001,
      eng_read = 3'b010,
      eng_write = 3'b100
   } burst_state_t;

   typedef enum logic [1:0] {
      st_normal = 2'b01,
      st_self = 2'b10
   } power_state_t;

   typedef struct packed {
      logic cke;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic bank_select_high;
      logic bank_select_low;
      logic [12:0] addr;
   } cmd_bus_t;

   typedef struct packed {
      logic [31:0] data;
      logic [3:0] write_byte_mask;
   } wr_pair_t;

   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } rd_pair_t;

endpackage : lpddr_pkg

// File: rtl/lpddr_refresh_engine.sv
// Purpose: Internal refresh row counter and self refresh timer.
// Assumes: temp_code comes from an on-die sensor outside this clock domain.
// Notes: Partial array masking applies only to refreshes made in self refresh.
`timescale 1ns/1ns
`include "lpddr_defines.svh"
module lpddr_refresh_engine #(
   parameter int ROW_W = 12
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic auto_req,
   input wire logic self_active,
   input wire logic self_enter,
   input wire logic [1:0] temp_code,
   input wire logic [2:0] array_code,
   input wire logic [15:0] interval,
   output logic [ROW_W-1:0] refresh_row_r,
   output logic [15:0] refresh_total_r
);
   logic [1:0] temp_meta_r;
   logic [1:0] temp_sync_r;
   logic [15:0] timer_r;
   logic [15:0] period;
   logic [ROW_W-1:0] array_mask;
   logic [ROW_W-1:0] row_nxt;
   logic timer_fire;
   logic fire;

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         temp_meta_r <= 2'h0;
         temp_sync_r <= 2'h0;
      end
      else if (ce)
      begin
         temp_meta_r <= temp_code;
         temp_sync_r <= temp_meta_r;
      end
   end

   // rate follows temperature.
   // A hotter code halves the interval per step, trading current for retention.
   always_comb
   begin
      period = interval >> temp_sync_r;
      if (period == 16'h0000)
         period = 16'h0001;
   end

   always_comb
   begin
      case (array_code)
         `ARRAY_HALF: array_mask = {ROW_W{1'b1}} >> 1;
         `ARRAY_QUARTER: array_mask = {ROW_W{1'b1}} >> 2;
         `ARRAY_EIGHTH: array_mask = {ROW_W{1'b1}} >> 3;
         `ARRAY_SIXTEENTH: array_mask = {ROW_W{1'b1}} >> 4;
         default: array_mask = {ROW_W{1'b1}};
      endcase
   end

   assign timer_fire = self_active && !self_enter && (timer_r == 16'h0000);
   assign fire = auto_req || self_enter || timer_fire;
   assign row_nxt = (self_active || self_enter) ? ((refresh_row_r + 1'b1) & array_mask)
                                                : ROW_W'(refresh_row_r + 1'b1);

   // one refresh at entry, then self timed.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         timer_r <= 16'h0000;
      else if (ce)
      begin
         if (self_enter || timer_fire)
            timer_r <= 16'(period - 16'h0001);
         else if (self_active)
            timer_r <= 16'(timer_r - 16'h0001);
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         refresh_row_r <= '0;
         refresh_total_r <= 16'h0000;
      end
      else if (ce && fire)
      begin
         refresh_row_r <= row_nxt;
         refresh_total_r <= 16'(refresh_total_r + 16'h0001);
      end
   end

   chk_sr_entry_refresh:
   assert property (@(posedge core_clk) disable iff (!resetn)
      ce && self_enter |=> refresh_total_r == 16'($past(refresh_total_r) + 16'h0001))
      else $error("self refresh entry did not refresh");

   chk_auto_row_step:
   assert property (@(posedge core_clk) disable iff (!resetn)
      ce && auto_req && !self_active && !self_enter
      |=> refresh_row_r == ROW_W'($past(refresh_row_r) + 1'b1))
      else $error("auto refresh row did not advance");

   chk_array_range:
   assert property (@(posedge core_clk) disable iff (!resetn)
      ce && timer_fire |=> (refresh_row_r & ~$past(array_mask)) == '0)
      else $error("self refresh row outside partial array");

endmodule : lpddr_refresh_engine

// File: test/lpddr_ctrl_model.sv
// Purpose: Controller side model driving commands and write pairs.
// Assumes: Each call of drive spans one clock cycle.
// Notes: Fully masked pairs carry toggled data, so stale data never looks valid.
`timescale 1ns/1ns
module lpddr_ctrl_model (
   input wire logic core_clk,
   output lpddr_pkg::cmd_bus_t cmd,
   output lpddr_pkg::wr_pair_t wr
);
   initial
   begin
      cmd = {1'b1, 1'b1, 18'h0};
      wr = {32'h0, 4'hF};
   end
   task automatic drive(input logic k, input logic [3:0] c, input logic [1:0] b,
      input logic [12:0] a, input logic [31:0] d, input logic [3:0] m);
      @(posedge core_clk);
      cmd <= {k, c == lpddr_pkg::cmd_nop, c[2:0], b, a};
      wr <= {(m == 4'hF) ? ~wr.data : d, m};
   endtask : drive
endmodule : lpddr_ctrl_model

// File: test/tb_lpddr_cmd_core.sv
// Purpose: Self-checking bench of the command core.
// Assumes: ce and temp_code are driven by the bench, commands by the model.
// Notes: Expected values come from reset values and command rules.
`timescale 1ns/1ns
`include "lpddr_defines.svh"
module tb_lpddr_cmd_core;
   logic core_clk = 0, resetn = 0, avs_read = 0, avs_write = 0, avs_waitrequest, ce = 1;
   logic [1:0] tc = 2'h0;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q, t, got[$];
   lpddr_pkg::cmd_bus_t cmd;
   lpddr_pkg::wr_pair_t wr;
   lpddr_pkg::rd_pair_t rd;
   int num_errors = 0, compares = 0, cyc = 0, rd_edge = 0, lat = 0;
   typedef struct {logic w; logic [5:0] a; logic [31:0] e;} row_t;
   row_t rows[6] = '{'{1'b0, 6'h00, 32'h0}, '{1'b1, 6'h04, 32'h0}, '{1'b0, 6'h04, 32'h32},
      '{1'b0, 6'h08, 32'h0}, '{1'b0, 6'h0C, 32'h79E}, '{1'b0, 6'h14, 32'h0}};
   lpddr_cmd_core lpddr_cmd_core_inst (.core_clk(core_clk), .resetn(resetn), .ce(ce),
      .cmd(cmd), .wr(wr), .rd(rd), .temp_code(tc), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   lpddr_ctrl_model lpddr_ctrl_model_inst (.core_clk(core_clk), .cmd(cmd), .wr(wr));
   initial
      forever #2 core_clk = ~core_clk;
   task automatic give_verdict();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         num_errors++;
         $display("FAIL %s exp %h got %h", n, e, s);
      end
   endtask : check
   // Holds the request until waitrequest is seen low at a rising edge.
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic c(input logic [3:0] k, input logic [1:0] b, input logic [12:0] a,
      input logic [31:0] d, input logic [3:0] m);
      lpddr_ctrl_model_inst.drive(1'b1, k, b, a, d, m);
   endtask : c
   task automatic n(input int x);
      repeat (x) c(lpddr_pkg::cmd_nop, 2'h0, 13'h0, 32'h0, 4'hF);
   endtask : n
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cmd.cs_n === 1'b0 && {cmd.ras_n, cmd.cas_n, cmd.we_n} === 3'b101)
         rd_edge <= cyc;
      if (rd.valid === 1'b1)
      begin
         if (got.size() == 0)
            lat <= cyc - rd_edge;
         got.push_back(rd.data);
      end
      if (cyc == 9000)
      begin
         num_errors++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      foreach (rows[i])
      begin
         bus(rows[i].w, rows[i].a, 32'hFF);
         if (!rows[i].w) check("reg", q, rows[i].e);
      end
      // modes set before the first activate.
      c(lpddr_pkg::cmd_mrs, 2'h0, 13'h32, 32'h0, 4'hF);
      c(lpddr_pkg::cmd_mrs, 2'h2, 13'h5, 32'h0, 4'hF);
      n(2);
      bus(1'b0, 6'h04, 32'h0);
      check("ext", q, 32'h5_0032);
      repeat (2) c(lpddr_pkg::cmd_ref, 2'h0, 13'h0, 32'h0, 4'hF);
      n(1);
      // A refresh taken while ce is low must leave the row counter alone.
      ce <= 1'b0;
      c(lpddr_pkg::cmd_ref, 2'h0, 13'h0, 32'h0, 4'hF);
      n(1);
      ce <= 1'b1;
      bus(1'b0, 6'h10, 32'h0);
      check("row", q, 32'h2);
      c(lpddr_pkg::cmd_act, 2'h0, 13'h0, 32'h0, 4'hF);
      n(1);
      c(lpddr_pkg::cmd_write, 2'h0, 13'h0, 32'h0, 4'hF);
      c(lpddr_pkg::cmd_nop, 2'h0, 13'h0, 32'h1111_1111, 4'h0);
      c(lpddr_pkg::cmd_nop, 2'h0, 13'h0, 32'h2222_2222, 4'h0);
      n(3);
      c(lpddr_pkg::cmd_write, 2'h0, 13'h0, 32'h0, 4'hF);
      c(lpddr_pkg::cmd_nop, 2'h0, 13'h0, 32'h3333_3333, 4'h0);
      c(lpddr_pkg::cmd_pre, 2'h0, 13'h0, 32'h4444_4444, 4'h0);
      n(6);
      c(lpddr_pkg::cmd_act, 2'h0, 13'h0, 32'h0, 4'hF);
      got.delete();
      c(lpddr_pkg::cmd_read, 2'h0, 13'h0, 32'h0, 4'hF);
      n(6);
      check("cut", got[1], 32'h2222_2222);
      check("lat", lat, 3);
      // terminate used on a read only.
      got.delete();
      c(lpddr_pkg::cmd_read, 2'h0, 13'h0, 32'h0, 4'hF);
      c(lpddr_pkg::cmd_bst, 2'h0, 13'h0, 32'h0, 4'hF);
      n(5);
      check("bst", got.size(), 1);
      c(lpddr_pkg::cmd_write, 2'h0, 13'h408, 32'h0, 4'hF);
      n(12);
      c(lpddr_pkg::cmd_pre, 2'h0, 13'h0, 32'h0, 4'hF);
      n(1);
      bus(1'b0, 6'h00, 32'h0);
      check("ap", q[7:0], 8'h00);
      c(lpddr_pkg::cmd_act, 2'h1, 13'h0, 32'h0, 4'hF);
      c(lpddr_pkg::cmd_act, 2'h2, 13'h0, 32'h0, 4'hF);
      c(lpddr_pkg::cmd_pre, 2'h0, 13'h400, 32'h0, 4'hF);
      n(1);
      bus(1'b0, 6'h00, 32'h0);
      check("all", q[7:0], 8'h60);
      n(6);
      c(lpddr_pkg::cmd_mrs, 2'h1, 13'h0, 32'h0, 4'hF);
      n(2);
      got.delete();
      c(lpddr_pkg::cmd_read, 2'h0, 13'h0, 32'h0, 4'hF);
      n(6);
      check("srr", got[0], `STATUS_ID);
      check("srn", got.size(), 1);
      // burst of eight, interleaved, latency two, banks idle.
      c(lpddr_pkg::cmd_mrs, 2'h0, 13'h2B, 32'h0, 4'hF);
      n(2);
      c(lpddr_pkg::cmd_act, 2'h0, 13'h0, 32'h0, 4'hF);
      got.delete();
      c(lpddr_pkg::cmd_read, 2'h0, 13'h1, 32'h0, 4'hF);
      n(7);
      check("lt2", lat, 2);
      check("ilv", got[0], 32'h3333_3333);
      check("bl8", got.size(), 4);
      c(lpddr_pkg::cmd_pre, 2'h0, 13'h0, 32'h0, 4'hF);
      tc <= 2'h1;
      bus(1'b1, 6'h0C, 32'h10);
      bus(1'b0, 6'h08, 32'h0);
      t = q;
      repeat (40) lpddr_ctrl_model_inst.drive(1'b0, lpddr_pkg::cmd_ref, 2'h0, 13'h0, 32'h0, 4'hF);
      bus(1'b0, 6'h00, 32'h0);
      check("sr", q[11], 1'b1);
      bus(1'b0, 6'h08, 32'h0);
      check("srt", {31'h0, q - t > 32'h4}, 32'h1);
      // no-operations after exit, then one extra refresh.
      n(1);
      bus(1'b0, 6'h00, 32'h0);
      check("sx", q[11], 1'b0);
      n(4);
      c(lpddr_pkg::cmd_ref, 2'h0, 13'h0, 32'h0, 4'hF);
      n(1);
      give_verdict();
   end
endmodule : tb_lpddr_cmd_core
